// ---- rtl/pms_params.svh ----
// Constants of the position measurement sequencer
`ifndef PMS_PARAMS_SVH
`define PMS_PARAMS_SVH

// ****************************************************************
// Timing, in nanoseconds
// ****************************************************************
`define PMS_CLK_PERIOD_NS    4
`define PMS_PULSE_TIME_NS    10000
`define PMS_ECHO_TIME_NS     10000
`define PMS_CALC_TIME_NS     8000
`define PMS_GUARD_TIME_NS    2000
`define PMS_DECAY_INC_NS     20000
`define PMS_DECAY_ABS_NS     40000
`define PMS_INTERVAL_UNIT_NS 100

// ****************************************************************
// Thresholds, field positions and reset values
// ****************************************************************
`define PMS_AMP_VALID_MIN    16'h0800
`define PMS_FINE_QUAD_MSB    15
`define PMS_FINE_QUAD_LSB    14
`define PMS_COARSE_PER_MSB   15
`define PMS_COARSE_PER_LSB   8
`define PMS_PERIOD_RESET     8'h00

`endif

// ---- rtl/pms_pkg.sv ----
// Types of the position measurement sequencer
package pms_pkg;

  // ****************************************************************
  // Sensor control word as written by the host
  // ****************************************************************
  typedef struct packed {
    logic go;
    logic overlap_mode_enable;
    logic fine_only_enable;
    logic indicator_enable;
    logic indicator_autoclear;
    logic indicator_flag;
  } pms_ctrl_s;

  // ****************************************************************
  // Status and results
  // ****************************************************************
  typedef struct packed {
    logic overlap_active_flag;
    logic fine_only_flag;
    logic indicator_flag;
    logic busy;
  } pms_status_s;

  typedef struct packed {
    logic [23:0] position;
    logic [15:0] amplitude;
    logic        valid;
    logic        fine_only;
    logic        fresh;
  } pms_result_s;

  typedef enum logic [2:0] {
    PMS_IDLE  = 3'b000,
    PMS_PULSE = 3'b001,
    PMS_ECHO  = 3'b010,
    PMS_CALC  = 3'b011,
    PMS_DECAY = 3'b100
  } pms_state_e;

endpackage : pms_pkg

// ---- rtl/pms_sequencer.sv ----
// Measurement sequencer: single shot and overlapped pipeline timing
`timescale 1ns/1ps
`include "pms_params.svh"
module pms_sequencer
  import pms_pkg::*;
#(
  parameter int CW        = 22,
  parameter int PULSE_CYC = `PMS_PULSE_TIME_NS / `PMS_CLK_PERIOD_NS,
  parameter int ECHO_CYC  = `PMS_ECHO_TIME_NS / `PMS_CLK_PERIOD_NS,
  parameter int CALC_CYC  = `PMS_CALC_TIME_NS / `PMS_CLK_PERIOD_NS,
  parameter int GUARD_CYC = (`PMS_GUARD_TIME_NS + `PMS_CLK_PERIOD_NS - 1)
                            / `PMS_CLK_PERIOD_NS,
  parameter int DECAY_INC = `PMS_DECAY_INC_NS / `PMS_CLK_PERIOD_NS,
  parameter int DECAY_ABS = `PMS_DECAY_ABS_NS / `PMS_CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // Control word and interval setting
  input  wire logic        ctrl_write,
  input  wire pms_ctrl_s   control,
  input  wire logic [15:0] interval_setting,
  // Host sync pin
  input  wire logic        sync_input_n,
  // Sensed echo data
  input  wire logic [15:0] fine_phase,
  input  wire logic [15:0] coarse_phase,
  input  wire logic [15:0] amplitude,
  // Coil drivers
  output logic             exc_drive,
  output logic             echo_window,
  output logic             echo_coarse,
  // Status, results and indicator pin
  output pms_status_s      status,
  output pms_result_s      result,
  output logic             indicator_out
);

  localparam logic [CW-1:0] PULSE_T = CW'(PULSE_CYC);
  localparam logic [CW-1:0] ECHO_T  = CW'(ECHO_CYC);
  localparam logic [CW-1:0] CALC_T  = CW'(CALC_CYC);
  // Three more cycles: timer reload, echo-to-calc handoff, result load
  localparam logic [CW-1:0] OVH_T   =
    CW'(ECHO_CYC + CALC_CYC + GUARD_CYC + 3);
  localparam logic [CW-1:0] DINC_T  = CW'(DECAY_INC);
  localparam logic [CW-1:0] DABS_T  = CW'(DECAY_ABS);
  localparam logic [CW-1:0] UNIT_T  =
    CW'(`PMS_INTERVAL_UNIT_NS / `PMS_CLK_PERIOD_NS);
  localparam logic [CW-1:0] ONE_T   = CW'(1);
  localparam logic [CW-1:0] HOLD_T  = '1;

  // ****************************************************************
  // Registers
  // ****************************************************************
  pms_state_e    state_reg;
  pms_ctrl_s     ctrl_reg;
  pms_result_s   live_reg;
  pms_result_s   result_reg;
  logic [CW-1:0] timer_reg;
  logic [CW-1:0] calc_cnt_reg;
  logic [CW-1:0] sync_cnt_reg;
  logic [CW-1:0] measured_reg;
  logic          pend_reg;
  logic          meas_abs_reg;
  logic          coil_coarse_reg;
  logic          calc_busy_reg;
  logic          calc_abs_reg;
  logic          abs_ok_reg;
  logic          indicator_reg;
  logic [15:0]   fine_reg;
  logic [15:0]   fine_prev_reg;
  logic [15:0]   coarse_reg;
  logic [15:0]   amp_reg;
  logic [7:0]    period_reg;

  // ****************************************************************
  // Decoding
  // ****************************************************************
  logic          sync_fall;
  logic          overlap_run;
  logic          do_absolute;
  logic          timer_zero;
  logic          echo_end;
  logic          last_echo;
  logic          calc_start;
  logic          calc_done;
  logic          res_valid;
  logic          meas_start;
  logic          single_go;
  logic [CW-1:0] interval_t;
  logic [CW-1:0] delay_tgt;
  logic [1:0]    quad_old;
  logic [1:0]    quad_new;
  logic [7:0]    period_next;

  pms_sync_edge u_sync (
    .core_clk (core_clk),
    .nrst     (nrst),
    .pin_in   (sync_input_n),
    .level    (),
    .fall     (sync_fall)
  );

  assign overlap_run = ctrl_reg.go & ctrl_reg.overlap_mode_enable;
  // Invalid results force absolute until a valid absolute arrives
  assign do_absolute = ~ctrl_reg.fine_only_enable | ~abs_ok_reg;
  assign single_go   = ctrl_write & control.go
                       & ~control.overlap_mode_enable;
  assign timer_zero  = (timer_reg == '0);
  assign echo_end    = (state_reg == PMS_ECHO) & timer_zero;
  assign last_echo   = ~meas_abs_reg | coil_coarse_reg;
  assign calc_start  = echo_end & (overlap_run | last_echo);
  assign calc_done   = calc_busy_reg & (calc_cnt_reg == '0);
  assign res_valid   = (amp_reg >= `PMS_AMP_VALID_MIN);
  assign meas_start  = (state_reg == PMS_IDLE)
                       & (overlap_run | pend_reg);

  // Zero setting selects the self-measured interval
  assign interval_t  = (interval_setting == 16'h0000) ? measured_reg
                       : CW'(interval_setting) * UNIT_T;
  // Time left for excitation once echo, calculation and guard fit
  assign delay_tgt   = (interval_t > OVH_T + ONE_T)
                       ? interval_t - OVH_T : ONE_T;

  assign quad_old    = fine_prev_reg[`PMS_FINE_QUAD_MSB:`PMS_FINE_QUAD_LSB];
  assign quad_new    = fine_reg[`PMS_FINE_QUAD_MSB:`PMS_FINE_QUAD_LSB];
  // Absolute takes the period from coarse; incremental counts wraps
  assign period_next = calc_abs_reg
    ? coarse_reg[`PMS_COARSE_PER_MSB:`PMS_COARSE_PER_LSB]
    : (quad_old == 2'b11 && quad_new == 2'b00) ? period_reg + 8'h01
    : (quad_old == 2'b00 && quad_new == 2'b11) ? period_reg - 8'h01
    : period_reg;

  assign exc_drive   = (state_reg == PMS_PULSE);
  assign echo_window = (state_reg == PMS_ECHO);
  assign echo_coarse = coil_coarse_reg;
  assign indicator_out = indicator_reg;
  assign result      = result_reg;
  assign status.overlap_active_flag = overlap_run
                       & (state_reg != PMS_IDLE);
  assign status.fine_only_flag = live_reg.fine_only;
  assign status.indicator_flag = indicator_reg;
  assign status.busy = (state_reg != PMS_IDLE) | calc_busy_reg;

  // ****************************************************************
  // Control word and trigger
  // ****************************************************************
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= '0;
      pend_reg <= 1'b0;
    end else begin
      if (ctrl_write) begin
        ctrl_reg <= control;
      end
      // A trigger landing during a measurement waits for idle
      if (single_go) begin
        pend_reg <= 1'b1;
      end else if (meas_start) begin
        pend_reg <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Interval measurement between sync falls
  // ****************************************************************
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sync_cnt_reg <= '0;
      measured_reg <= '0;
    end else if (sync_fall) begin
      sync_cnt_reg <= ONE_T;
      measured_reg <= sync_cnt_reg;
    end else if (sync_cnt_reg != HOLD_T) begin
      sync_cnt_reg <= sync_cnt_reg + ONE_T;
    end
  end

  // ****************************************************************
  // Pulse and echo sequencer
  // ****************************************************************
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg       <= PMS_IDLE;
      timer_reg       <= '0;
      meas_abs_reg    <= 1'b1;
      coil_coarse_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        PMS_IDLE: begin
          if (overlap_run) begin
            // No warm-up: excitation runs until the sync-timed end
            state_reg       <= PMS_PULSE;
            timer_reg       <= delay_tgt;
            meas_abs_reg    <= do_absolute;
            coil_coarse_reg <= do_absolute;
          end else if (pend_reg) begin
            state_reg       <= PMS_PULSE;
            timer_reg       <= PULSE_T;
            meas_abs_reg    <= do_absolute;
            coil_coarse_reg <= 1'b0;
          end
        end
        PMS_PULSE: begin
          if (ctrl_reg.overlap_mode_enable && !overlap_run) begin
            state_reg <= PMS_IDLE;
          end else if (overlap_run && sync_fall) begin
            timer_reg <= delay_tgt;
          end else if (timer_zero) begin
            state_reg <= PMS_ECHO;
            timer_reg <= ECHO_T;
          end else begin
            timer_reg <= timer_reg - ONE_T;
          end
        end
        PMS_ECHO: begin
          if (!timer_zero) begin
            timer_reg <= timer_reg - ONE_T;
          end else if (overlap_run) begin
            // Keep the resonator driven while calculation runs
            state_reg       <= PMS_PULSE;
            timer_reg       <= HOLD_T;
            meas_abs_reg    <= do_absolute;
            coil_coarse_reg <= do_absolute;
          end else if (!last_echo) begin
            state_reg       <= PMS_PULSE;
            timer_reg       <= PULSE_T;
            coil_coarse_reg <= 1'b1;
          end else begin
            state_reg <= PMS_CALC;
          end
        end
        PMS_CALC: begin
          if (calc_done) begin
            state_reg <= PMS_DECAY;
            timer_reg <= meas_abs_reg ? DABS_T : DINC_T;
          end
        end
        PMS_DECAY: begin
          if (timer_zero) begin
            state_reg <= PMS_IDLE;
          end else begin
            timer_reg <= timer_reg - ONE_T;
          end
        end
        default: begin
          state_reg <= PMS_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Echo capture and position calculation
  // ****************************************************************
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fine_reg      <= '0;
      fine_prev_reg <= '0;
      coarse_reg    <= '0;
      amp_reg       <= '0;
      calc_busy_reg <= 1'b0;
      calc_cnt_reg  <= '0;
      calc_abs_reg  <= 1'b1;
    end else begin
      if (echo_end && coil_coarse_reg) begin
        coarse_reg <= coarse_phase;
      end else if (echo_end) begin
        fine_prev_reg <= fine_reg;
        fine_reg      <= fine_phase;
      end
      if (echo_end) begin
        amp_reg <= amplitude;
      end
      if (calc_start) begin
        calc_busy_reg <= 1'b1;
        calc_cnt_reg  <= CALC_T;
        calc_abs_reg  <= meas_abs_reg;
      end else if (calc_done) begin
        calc_busy_reg <= 1'b0;
      end else if (calc_busy_reg) begin
        calc_cnt_reg <= calc_cnt_reg - ONE_T;
      end
    end
  end

  // ****************************************************************
  // Results, absolute validity and indicator
  // ****************************************************************
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      live_reg      <= '0;
      result_reg    <= '0;
      period_reg    <= `PMS_PERIOD_RESET;
      abs_ok_reg    <= 1'b0;
      indicator_reg <= 1'b0;
    end else begin
      if (calc_done) begin
        period_reg         <= period_next;
        live_reg.position  <= {period_next, fine_reg};
        live_reg.amplitude <= amp_reg;
        live_reg.valid     <= res_valid;
        live_reg.fine_only <= ~calc_abs_reg;
        live_reg.fresh     <= 1'b1;
        abs_ok_reg         <= res_valid & (calc_abs_reg | abs_ok_reg);
      end else if (sync_fall) begin
        live_reg.fresh <= 1'b0;
      end
      // Read edge takes what finished before it, else older data
      if (sync_fall) begin
        result_reg <= live_reg;
      end
      // Completion set wins over any clear in the same cycle
      if (calc_done && ctrl_reg.indicator_enable) begin
        indicator_reg <= 1'b1;
      end else if (meas_start && ctrl_reg.indicator_autoclear) begin
        indicator_reg <= 1'b0;
      end else if (ctrl_write && !control.indicator_flag) begin
        indicator_reg <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_flag_clear_off: assert property (
    !(ctrl_reg.go && ctrl_reg.overlap_mode_enable)
      |-> !status.overlap_active_flag)
    else $error("overlap flag set while disabled");
  a_flag_set_run: assert property (
    ($rose(overlap_run) ##1 overlap_run) |-> status.overlap_active_flag)
    else $error("overlap flag missing while running");
  a_drive_echo_excl: assert property (
    !(exc_drive && echo_window))
    else $error("excitation during echo");
  a_sync_pulse_end: assert property (
    (state_reg == PMS_PULSE && overlap_run && sync_fall)
      |=> timer_reg == $past(delay_tgt))
    else $error("pulse end not placed from sync");
  a_single_start: assert property (
    (state_reg == PMS_IDLE && pend_reg && !overlap_run)
      |=> exc_drive ##1 exc_drive)
    else $error("trigger did not start pulse");
  a_indic_on_done: assert property (
    (calc_done && ctrl_reg.indicator_enable) |=> indicator_out)
    else $error("indicator not raised");
  a_invalid_forces: assert property (
    (calc_done && !res_valid) |=> !abs_ok_reg && do_absolute)
    else $error("invalid result did not force absolute");
  a_fine_flag_src: assert property (
    calc_done |=> status.fine_only_flag == !$past(calc_abs_reg))
    else $error("fine-only flag wrong");
  a_auto_interval: assert property (
    sync_fall |=> measured_reg == $past(sync_cnt_reg))
    else $error("interval not measured");
  a_read_snapshot: assert property (
    sync_fall |=> result == $past(live_reg))
    else $error("read did not take completed results");
  a_echo_fixed: assert property (
    $rose(echo_window) |-> echo_window[*8])
    else $error("echo cut short");

endmodule // pms_sequencer

// ---- rtl/pms_sync_edge.sv ----
// Two-stage synchroniser with falling edge detect
`timescale 1ns/1ps
module pms_sync_edge (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic nrst,
  // Asynchronous pin
  input  wire logic pin_in,
  // Synchronised view
  output logic      level,
  output logic      fall
);

  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // Reset high: an idle active-low line must not look like an edge
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      last_reg <= 1'b1;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  assign fall  = last_reg & ~sync_reg;

endmodule // pms_sync_edge

// ---- verif/pms_host_model.sv ----
// Host model: drives the select line that is tied to the sync input
`timescale 1ns/1ps
module pms_host_model (
  // Frame control
  input  wire logic        run,
  input  wire logic [15:0] period_ns,
  // Select line
  output logic             sync_input_n
);
  // ****************************************************************
  // Frames
  // ****************************************************************
  // Select stays high between frames, never floats
  initial begin
    sync_input_n = 1'b1;
    forever begin
      wait (run);
      sync_input_n = 1'b0;
      #64;
      sync_input_n = 1'b1;
      #(period_ns - 16'd64);
    end
  end
endmodule // pms_host_model

// ---- verif/tb_top.sv ----
// Self-checking testbench of the measurement sequencer
`timescale 1ns/1ps
module tb_top
  import pms_pkg::*;
;
  typedef struct packed {
    logic [15:0] fine;
    logic [15:0] coarse;
    logic [15:0] amp;
    logic        inc;
    logic        xc;
    logic        xv;
    logic        xfo;
    logic [23:0] pos;
  } pms_tb_shot_s;

  logic         core_clk = 1'b0;
  logic         nrst = 1'b0;
  logic         ctrl_write = 1'b0;
  pms_ctrl_s    control = '0;
  logic [15:0]  interval_setting = 16'h0000;
  logic [15:0]  fine_phase = 16'h0000;
  logic [15:0]  coarse_phase = 16'h0000;
  logic [15:0]  amplitude = 16'h0000;
  logic         run = 1'b0;
  logic [15:0]  period_ns = 16'd400;
  logic         sync_input_n;
  logic         exc_drive;
  logic         echo_window;
  logic         echo_coarse;
  pms_status_s  status;
  pms_result_s  result;
  logic         indicator_out;
  logic         saw_coarse = 1'b0;
  logic         watch = 1'b0;
  int           gaps = 0;
  int           fail_count = 0;
  int           num_checks = 0;
  pms_ctrl_s    base;
  pms_ctrl_s    c;
  pms_tb_shot_s shots [7];

  always #2 core_clk = ~core_clk;

  pms_host_model host_u (
    .run          (run),
    .period_ns    (period_ns),
    .sync_input_n (sync_input_n)
  );

  // Small counts keep the run short; absolute decay keeps its real length
  pms_sequencer #(.PULSE_CYC(8), .ECHO_CYC(8), .CALC_CYC(8), .GUARD_CYC(2),
                  .DECAY_INC(8)) dut_u (
    .core_clk         (core_clk),
    .nrst             (nrst),
    .ctrl_write       (ctrl_write),
    .control          (control),
    .interval_setting (interval_setting),
    .sync_input_n     (sync_input_n),
    .fine_phase       (fine_phase),
    .coarse_phase     (coarse_phase),
    .amplitude        (amplitude),
    .exc_drive        (exc_drive),
    .echo_window      (echo_window),
    .echo_coarse      (echo_coarse),
    .status           (status),
    .result           (result),
    .indicator_out    (indicator_out)
  );

  always @(posedge core_clk) begin
    if (echo_window && echo_coarse) saw_coarse <= 1'b1;
    if (watch && !exc_drive && !echo_window) gaps <= gaps + 1;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task summarize;
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  // Bounded wait: 0 busy, 1 exc_drive, 2 select line
  task wait_for(input int sel, input logic lvl, input int lim);
    logic v;
    for (int i = 0; i < lim; i++) begin
      v = (sel == 0) ? status.busy : (sel == 1) ? exc_drive : sync_input_n;
      if (v === lvl) return;
      @(negedge core_clk);
    end
    fail_count++;
    $display("[ERR] wait %0d expected %b seen timeout", sel, lvl);
    summarize;
  endtask

  task wr(input pms_ctrl_s w);
    @(negedge core_clk);
    control = w;
    ctrl_write = 1'b1;
    @(negedge core_clk);
    ctrl_write = 1'b0;
  endtask

  // One select frame makes the results visible
  task latch;
    run = 1'b1;
    wait_for(2, 1'b0, 200);
    run = 1'b0;
    repeat (6) @(negedge core_clk);
  endtask

  task shot(input pms_tb_shot_s s);
    fine_phase = s.fine;
    coarse_phase = s.coarse;
    amplitude = s.amp;
    saw_coarse = 1'b0;
    c = base;
    c.fine_only_enable = s.inc;
    wr(c);
    chk("exc_early", 32'h0, 32'(exc_drive));
    @(posedge core_clk);
    #1 chk("exc_start", 32'h1, 32'(exc_drive));
    chk("ind_clear", 32'h0, 32'(indicator_out));
    wait_for(0, 1'b0, 11000);
    chk("ind_set", 32'h1, 32'(indicator_out));
    chk("ind_flag", 32'h1, 32'(status.indicator_flag));
    chk("fo_flag", 32'(s.xfo), 32'(status.fine_only_flag));
    chk("coarse_echo", 32'(s.xc), 32'(saw_coarse));
    latch;
    chk("valid", 32'(s.xv), 32'(result.valid));
    chk("fine_only", 32'(s.xfo), 32'(result.fine_only));
    if (s.xv) chk("position", 32'(s.pos), 32'(result.position));
    chk("fresh", 32'h1, 32'(result.fresh));
  endtask

  task frames(input int n);
    for (int k = 0; k < n; k++) begin
      wait_for(2, 1'b0, 200);
      repeat (6) @(negedge core_clk);
      if (k > 1) chk("ovl_fresh", 32'h1, 32'(result.fresh));
      wait_for(2, 1'b1, 200);
    end
  endtask

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    base = '{go: 1'b1, overlap_mode_enable: 1'b0, fine_only_enable: 1'b1,
             indicator_enable: 1'b1, indicator_autoclear: 1'b1,
             indicator_flag: 1'b0};
    shots[0] = '{16'h1234, 16'h3400, 16'h1000, 1'b1, 1'b1, 1'b1, 1'b0,
                 24'h341234};
    shots[1] = '{16'h8000, 16'h3400, 16'h1000, 1'b1, 1'b0, 1'b1, 1'b1,
                 24'h348000};
    shots[2] = '{16'hF000, 16'h3400, 16'h1000, 1'b1, 1'b0, 1'b1, 1'b1,
                 24'h34F000};
    // Fine wrap from top quadrant counts one period up
    shots[3] = '{16'h1000, 16'h3400, 16'h1000, 1'b1, 1'b0, 1'b1, 1'b1,
                 24'h351000};
    shots[4] = '{16'h1100, 16'h3400, 16'h0100, 1'b1, 1'b0, 1'b0, 1'b1,
                 24'h000000};
    shots[5] = '{16'h1100, 16'h5600, 16'h1000, 1'b1, 1'b1, 1'b1, 1'b0,
                 24'h561100};
    shots[6] = '{16'h2000, 16'h7700, 16'h1000, 1'b0, 1'b1, 1'b1, 1'b0,
                 24'h772000};
    repeat (2) @(negedge core_clk);
    chk("rst_exc", 32'h0, 32'(exc_drive));
    chk("rst_status", 32'h0, 32'(status));
    chk("rst_ind", 32'h0, 32'(indicator_out));
    @(negedge core_clk);
    nrst = 1'b1;
    for (int i = 0; i < 7; i++) shot(shots[i]);
    // Trigger while busy waits for idle
    wr(base);
    repeat (5) @(negedge core_clk);
    wr(base);
    wait_for(0, 1'b0, 400);
    wait_for(1, 1'b1, 20);
    wait_for(0, 1'b0, 400);
    // Overlapped run, set interval first, then interval self-measured from sync falls
    interval_setting = 16'd2;
    period_ns = 16'd200;
    c = base;
    c.overlap_mode_enable = 1'b1;
    wr(c);
    repeat (2) @(posedge core_clk);
    #1 chk("ovl_flag", 32'h1, 32'(status.overlap_active_flag));
    @(negedge core_clk);
    watch = 1'b1;
    run = 1'b1;
    frames(8);
    interval_setting = 16'h0000;
    frames(8);
    watch = 1'b0;
    chk("ovl_gaps", 32'h0, 32'(gaps));
    run = 1'b0;
    c.go = 1'b0;
    wr(c);
    repeat (3) @(posedge core_clk);
    #1 chk("ovl_stop", 32'h0, 32'(status.overlap_active_flag));
    chk("ovl_exc", 32'h0, 32'(exc_drive));
    summarize;
  end
endmodule // tb_top
